// >>> logic/i2crp_top.sv
/*
 * Two-wire target port and register file of a step-down regulator.
 * Assumes a 200 MHz system clock, well above the link bit rate, and an
 * external pull-up on the data line; the pin is driven only low.
 */
`timescale 1ns/1ps
`include "i2crp_regs.svh"
module i2crp_top (
    // System clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    // Link pins
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_O,
    // Device pins and monitors
    input  wire logic [5:0]  RESISTOR_SETTING_PIN_I,
    input  wire logic        VOLTAGE_SELECT_INPUT_I,
    input  wire logic        ENABLE_I,
    input  wire logic        SUPPLY_FAIL_I,
    input  wire logic        THERMAL_WARN_I,
    input  wire logic        HICCUP_I,
    input  wire logic        UVLO_I,
    // Regulator controls
    output logic [7:0]       ACTIVE_VOLTAGE_CODE_O,
    output logic [10:0]      TARGET_MV_O,
    output logic [7:0]       CONFIGURATION_O,
    output logic             STARTUP_BUSY_O,
    output logic             HS_MODE_O
);
    logic [`I2CRP_SYNC_W-1:0] sync_w;
    logic                     scl_s;
    logic                     sda_s;
    logic                     en_s;
    logic                     fail_s;
    logic                     therm_s;
    logic                     hiccup_s;
    logic                     uvlo_s;
    logic                     vsel_s;
    logic [5:0]               strap_s;
    logic                     scl_d_r;
    logic                     sda_d_r;
    logic                     en_d_r;
    logic                     start_ev;
    logic                     stop_ev;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     byte_ev;
    logic                     ack_end;
    logic                     is_hs_code;
    logic                     addr_hit;
    logic [7:0]               rx;
    i2crp_pkg::i2crp_phase_e  phase_r;
    logic [3:0]               bit_cnt_r;
    logic                     ack_pend_r;
    logic                     commit_pend_r;
    logic [7:0]               reg_ptr_r;
    logic [7:0]               wdata_r;
    logic [7:0]               tx_r;
    logic                     hs_r;
    logic                     sda_oe_r;
    logic [7:0]               vout_a_r;
    logic [7:0]               vout_b_r;
    logic [7:0]               ctrl_r;
    logic [7:0]               status_r;
    logic [7:0]               status_set;
    logic                     status_clr;
    logic [7:0]               rd_val;
    logic                     commit;
    logic                     ctrl_reset_wr;
    logic                     reg_reset;
    logic [15:0]              busy_cnt_r;
    logic                     busy_r;
    logic [7:0]               active_nxt;
    logic [7:0]               active_r;
    logic [10:0]              target_r;

    i2crp_link_if link ();

    // Pin levels enter the system domain through two flops
    i2crp_sync #(.W(`I2CRP_SYNC_W)) u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (NRST_I),
        .async_i ({SCL_I, SDA_I, ENABLE_I, SUPPLY_FAIL_I, THERMAL_WARN_I, HICCUP_I, UVLO_I,
                   VOLTAGE_SELECT_INPUT_I, RESISTOR_SETTING_PIN_I}),
        .sync_o  (sync_w)
    );
    assign {scl_s, sda_s, en_s, fail_s, therm_s, hiccup_s, uvlo_s, vsel_s, strap_s} = sync_w;

    // Bits shifted on the link clock itself
    i2crp_link_shift u_shift (
        .scl_clk_i (SCL_I),
        .sda_i     (SDA_I),
        .link      (link.shifter)
    );

    // Delayed copies for edge detection
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            en_d_r  <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            en_d_r  <= en_s;
        end
    end

    // Bus conditions and clock edges
    assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign byte_ev  = scl_rise && (bit_cnt_r == `I2CRP_LAST_DATA_BIT);
    assign ack_end  = scl_fall && (bit_cnt_r == `I2CRP_ACK_SLOT);

    // Shifter output is settled long before the synchronised edge arrives
    assign rx         = link.rx_byte;
    assign is_hs_code = (rx[7:3] == `I2CRP_HS_CODE);
    assign addr_hit   = (rx[7:1] == {`I2CRP_ADDR_MSB, strap_s});

    // Transfer phase
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            phase_r <= i2crp_pkg::PH_IDLE;
        end else if (start_ev) begin
            phase_r <= i2crp_pkg::PH_ADDR;
        end else if (stop_ev) begin
            phase_r <= i2crp_pkg::PH_IDLE;
        end else if (byte_ev) begin
            case (phase_r)
                i2crp_pkg::PH_ADDR: begin
                    if (is_hs_code) begin
                        phase_r <= i2crp_pkg::PH_IGNORE;
                    end else if (addr_hit) begin
                        phase_r <= rx[`I2CRP_DIR_BIT] ? i2crp_pkg::PH_RDATA : i2crp_pkg::PH_REG;
                    end else begin
                        phase_r <= i2crp_pkg::PH_IGNORE;
                    end
                end
                i2crp_pkg::PH_REG: phase_r <= i2crp_pkg::PH_WDATA;
                default: ;
            endcase
        end else if (scl_rise && bit_cnt_r == `I2CRP_BYTE_DONE && phase_r == i2crp_pkg::PH_RDATA && sda_s) begin
            phase_r <= i2crp_pkg::PH_IGNORE;  // Master NACK ends the read
        end
    end

    // Bit position within the nine-clock group
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || start_ev || stop_ev) begin
            bit_cnt_r <= 4'h0;
        end else if (ack_end) begin
            bit_cnt_r <= 4'h0;
        end else if (scl_rise && bit_cnt_r != `I2CRP_ACK_SLOT) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Acknowledge and commit bookkeeping
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || start_ev || stop_ev) begin
            ack_pend_r    <= 1'b0;
            commit_pend_r <= 1'b0;
        end else if (byte_ev) begin
            ack_pend_r    <= (phase_r == i2crp_pkg::PH_ADDR && !is_hs_code && addr_hit)
                          || phase_r == i2crp_pkg::PH_REG || phase_r == i2crp_pkg::PH_WDATA;
            commit_pend_r <= (phase_r == i2crp_pkg::PH_WDATA);
        end else if (ack_end) begin
            ack_pend_r    <= 1'b0;
            commit_pend_r <= 1'b0;
        end
    end

    // Pointer and write data; the pointer survives a repeated start
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            reg_ptr_r <= 8'h00;
            wdata_r   <= 8'h00;
        end else if (byte_ev && phase_r == i2crp_pkg::PH_REG) begin
            reg_ptr_r <= rx;
        end else if (byte_ev && phase_r == i2crp_pkg::PH_WDATA) begin
            wdata_r   <= rx;
        end
    end

    // High-speed mode lasts until a stop
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || stop_ev) begin
            hs_r <= 1'b0;
        end else if (byte_ev && phase_r == i2crp_pkg::PH_ADDR && is_hs_code) begin
            hs_r <= 1'b1;
        end
    end

    // Read mux; full-byte compare so pointers with upper bits set read zero
    always_comb begin
        if (reg_ptr_r == `I2CRP_OFS_VOUT_A) begin
            rd_val = vout_a_r;
        end else if (reg_ptr_r == `I2CRP_OFS_VOUT_B) begin
            rd_val = vout_b_r;
        end else if (reg_ptr_r == `I2CRP_OFS_CTRL) begin
            rd_val = ctrl_r;
        end else if (reg_ptr_r == `I2CRP_OFS_STATUS) begin
            rd_val = status_r;
        end else begin
            rd_val = 8'h00;
        end
    end

    // Transmit byte loaded as the previous acknowledge clock falls
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            tx_r <= 8'h00;
        end else if (ack_end && phase_r == i2crp_pkg::PH_RDATA) begin
            tx_r <= rd_val;
        end
    end

    // Data line drive changes on a falling clock or is released at a start or stop, so it holds while a bit's clock is high
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || start_ev || stop_ev) begin
            sda_oe_r <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt_r == `I2CRP_BYTE_DONE) begin
                sda_oe_r <= ack_pend_r;
            end else if (ack_end && phase_r == i2crp_pkg::PH_RDATA) begin
                sda_oe_r <= !rd_val[7];
            end else if (phase_r == i2crp_pkg::PH_RDATA && bit_cnt_r != 4'h0 && bit_cnt_r != `I2CRP_ACK_SLOT) begin
                sda_oe_r <= !tx_r[3'(`I2CRP_LAST_DATA_BIT - bit_cnt_r)];
            end else begin
                sda_oe_r <= 1'b0;
            end
        end
    end

    // Write strobes and register reset sources
    assign commit        = ack_end && commit_pend_r && !busy_r;
    assign ctrl_reset_wr = commit && reg_ptr_r == `I2CRP_OFS_CTRL && wdata_r[`I2CRP_CTRL_RESET_BIT];
    assign reg_reset     = fail_s || (en_d_r && !en_s) || ctrl_reset_wr;

    // Writable registers; the reset bit self-clears rather than being stored
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || reg_reset) begin
            vout_a_r <= `I2CRP_RST_VOUT;
            vout_b_r <= `I2CRP_RST_VOUT;
            ctrl_r   <= `I2CRP_RST_CTRL;
        end else if (commit) begin
            if (reg_ptr_r == `I2CRP_OFS_VOUT_A) begin
                vout_a_r <= wdata_r;
            end else if (reg_ptr_r == `I2CRP_OFS_VOUT_B) begin
                vout_b_r <= wdata_r;
            end else if (reg_ptr_r == `I2CRP_OFS_CTRL) begin
                ctrl_r   <= wdata_r;
            end
        end
    end

    // Status flags stick until read; a new event beats the read-clear
    assign status_clr = ack_end && phase_r == i2crp_pkg::PH_RDATA && reg_ptr_r == `I2CRP_OFS_STATUS;
    always_comb begin
        status_set = 8'h00;
        status_set[`I2CRP_STAT_THERM_BIT]  = therm_s;
        status_set[`I2CRP_STAT_HICCUP_BIT] = hiccup_s;
        status_set[`I2CRP_STAT_UVLO_BIT]   = uvlo_s;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I || reg_reset) begin
            status_r <= `I2CRP_RST_STATUS;
        end else begin
            status_r <= (status_clr ? 8'h00 : status_r) | status_set;
        end
    end

    // New power-up after a reset-bit write; writes are refused meanwhile
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            busy_cnt_r <= 16'h0000;
            busy_r     <= 1'b0;
        end else if (ctrl_reset_wr) begin
            busy_cnt_r <= `I2CRP_STARTUP_CYCLES;
            busy_r     <= 1'b1;
        end else if (busy_cnt_r != 16'h0000) begin
            busy_cnt_r <= busy_cnt_r - 16'h0001;
            busy_r     <= (busy_cnt_r != 16'h0001);
        end
    end

    // Active code follows the select input once start-up is over
    assign active_nxt = busy_r ? active_r : (vsel_s ? vout_b_r : vout_a_r);
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            active_r <= `I2CRP_RST_VOUT;
            target_r <= `I2CRP_VMIN_MV + 11'(`I2CRP_RST_VOUT) * `I2CRP_VSTEP_MV;
        end else begin
            active_r <= active_nxt;
            target_r <= `I2CRP_VMIN_MV + 11'(active_nxt) * `I2CRP_VSTEP_MV;
        end
    end

    // Outputs; the pin is open drain so its data is always low
    assign SDA_O                 = 1'b0;
    assign SDA_OE_O              = sda_oe_r;
    assign HS_MODE_O             = hs_r;
    assign CONFIGURATION_O       = ctrl_r;
    assign STARTUP_BUSY_O        = busy_r;
    assign ACTIVE_VOLTAGE_CODE_O = active_r;
    assign TARGET_MV_O           = target_r;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_ack_fall;
        scl_fall && bit_cnt_r == `I2CRP_BYTE_DONE && ack_pend_r && !start_ev && !stop_ev;
    endsequence
    sequence s_write_commit;
        ack_end && commit_pend_r && !busy_r && reg_ptr_r == `I2CRP_OFS_VOUT_A && !fail_s && !(en_d_r && !en_s);
    endsequence
    start_enter_a: assert property (start_ev |=> phase_r == i2crp_pkg::PH_ADDR && bit_cnt_r == 4'h0 && !sda_oe_r)
        else $error("start not taken");
    stop_release_a: assert property (stop_ev |=> phase_r == i2crp_pkg::PH_IDLE && !sda_oe_r && !hs_r)
        else $error("stop did not release");
    ack_drive_a: assert property (s_ack_fall |=> sda_oe_r)
        else $error("acknowledge not driven");
    sda_stable_a: assert property ($changed(sda_oe_r) |-> $past(scl_fall || start_ev || stop_ev)
                                   && (!scl_s || $past(start_ev || stop_ev)))
        else $error("data line changed outside clock low");
    hs_noack_a: assert property (byte_ev && phase_r == i2crp_pkg::PH_ADDR && is_hs_code && !start_ev && !stop_ev
                                 |=> hs_r && !ack_pend_r)
        else $error("master code handled wrongly");
    unmapped_zero_a: assert property (reg_ptr_r != `I2CRP_OFS_VOUT_A && reg_ptr_r != `I2CRP_OFS_VOUT_B &&
                                      reg_ptr_r != `I2CRP_OFS_CTRL && reg_ptr_r != `I2CRP_OFS_STATUS
                                      |-> rd_val == 8'h00)
        else $error("unmapped read not zero");
    write_commit_a: assert property (s_write_commit |=> vout_a_r == $past(wdata_r))
        else $error("write not committed");
    fail_reset_a: assert property (fail_s |=> vout_a_r == `I2CRP_RST_VOUT && vout_b_r == `I2CRP_RST_VOUT
                                   && ctrl_r == `I2CRP_RST_CTRL && status_r == `I2CRP_RST_STATUS)
        else $error("supply fail did not reset registers");
    ctrl_reset_a: assert property (ctrl_reset_wr |=> busy_r && ctrl_r == `I2CRP_RST_CTRL ##1 busy_r)
        else $error("reset bit did not restart");
    vid_select_a: assert property (!busy_r && !$past(busy_r) |=> active_r == ($past(vsel_s) ? $past(vout_b_r)
                                   : $past(vout_a_r)))
        else $error("wrong active code");
endmodule : i2crp_top

// >>> include/i2crp_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * regulator register port. Assumes a 200 MHz system clock.
 */
`ifndef I2CRP_REGS_SVH
`define I2CRP_REGS_SVH

// Register pointers
`define I2CRP_OFS_VOUT_A        8'h01
`define I2CRP_OFS_VOUT_B        8'h02
`define I2CRP_OFS_CTRL          8'h03
`define I2CRP_OFS_STATUS        8'h05

// Reset values
`define I2CRP_RST_VOUT          8'h64
`define I2CRP_RST_CTRL          8'h6f
`define I2CRP_RST_STATUS        8'h00

// Control and status fields
`define I2CRP_CTRL_RESET_BIT    7
`define I2CRP_STAT_THERM_BIT    4
`define I2CRP_STAT_HICCUP_BIT   3
`define I2CRP_STAT_UVLO_BIT     0

// Address byte layout
`define I2CRP_ADDR_MSB          1'b1
`define I2CRP_HS_CODE           5'h01
`define I2CRP_DIR_BIT           0

// Bit slots within a nine-clock group
`define I2CRP_LAST_DATA_BIT     4'h7
`define I2CRP_BYTE_DONE         4'h8
`define I2CRP_ACK_SLOT          4'h9

// Voltage code mapping in millivolts
`define I2CRP_VMIN_MV           11'h190
`define I2CRP_VSTEP_MV          11'h005

// Start-up delay
`define I2CRP_CLK_PERIOD_NS     5
`define I2CRP_STARTUP_DELAY_NS  1000
`define I2CRP_STARTUP_CYCLES    16'((`I2CRP_STARTUP_DELAY_NS + `I2CRP_CLK_PERIOD_NS - 1) / `I2CRP_CLK_PERIOD_NS)

// Synchroniser bundle width
`define I2CRP_SYNC_W            14

`endif

// >>> include/i2crp_pkg.sv
/*
 * Types shared by the regulator register port.
 * Assumes nothing of its surroundings.
 */
package i2crp_pkg;

    // Where the target stands inside a transfer
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_REG,
        PH_WDATA,
        PH_RDATA,
        PH_IGNORE
    } i2crp_phase_e;

endpackage : i2crp_pkg

// >>> include/i2crp_link_if.sv
/*
 * Carrier for the byte shifted in on the link clock.
 * Assumes the shifter owns rx_byte and the core only reads it.
 */
`timescale 1ns/1ps
interface i2crp_link_if;
    logic [7:0] rx_byte;

    modport shifter (output rx_byte);
    modport core    (input  rx_byte);
endinterface : i2crp_link_if

// >>> logic/i2crp_sync.sv
/*
 * Two-flop synchronisers, one per bit of a bundle of pin levels.
 * Assumes each bit is a slow level or is oversampled by the clock.
 */
`timescale 1ns/1ps
module i2crp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    // First flop feeds only the second one
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                meta_r[i] <= 1'b0;
                sync_o[i] <= 1'b0;
            end else begin
                meta_r[i] <= async_i[i];
                sync_o[i] <= meta_r[i];
            end
        end
    end
endmodule : i2crp_sync

// >>> logic/i2crp_link_shift.sv
/*
 * Link-clock shifter: samples the data line on every rising clock edge.
 * Assumes data is stable while the link clock is high.
 */
`timescale 1ns/1ps
module i2crp_link_shift (
    // Link clock and data
    input  wire logic   scl_clk_i,
    input  wire logic   sda_i,
    // Toward the core
    i2crp_link_if.shifter link
);
    // No reset: the core frames bytes itself, and the link clock may stand still
    always_ff @(posedge scl_clk_i) begin
        link.rx_byte <= {link.rx_byte[6:0], sda_i};
    end
endmodule : i2crp_link_shift

// >>> tb/i2crp_master_model.sv
/*
 * Bus master model: drives the link clock and an open-drain data line.
 * Assumes the bench resolves the data line with a pull-up and feeds it back.
 */
`timescale 1ns/1ps
module i2crp_master_model (
    // Pacing clock and resolved line
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Driven link
    output logic      scl_o,
    output logic      sda_low_o
);
    // Link timed by delays, not by the system clock, so the two domains drift apart
    localparam realtime QUARTER_NS = 20.0;
    localparam realtime SKEW_NS    = 1.3;

    // Quarter link period is 20 ns, 80 ns per bit; n counts quarter quarters of 5 ns
    task automatic wt(input int n);
        #(n * QUARTER_NS / 4.0);
    endtask : wt

    // Clock stands high outside frames
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // Start or repeated start
    task automatic start();
        #(SKEW_NS);
        wt(4);
        sda_low_o = 1'b0;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_low_o = 1'b1;
        wt(8);
        scl_o = 1'b0;
    endtask : start

    // Stop leaves both lines released
    task automatic stop();
        wt(4);
        sda_low_o = 1'b1;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_low_o = 1'b0;
        wt(8);
        // Back onto a falling system edge so bench checks stay off the sampling edge
        @(negedge clk_i);
    endtask : stop

    // One clock pulse; data moves only while the clock is low
    task automatic clk_bit(input logic b, output logic got);
        wt(4);
        sda_low_o = ~b;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        got = sda_i;
        wt(4);
        scl_o = 1'b0;
    endtask : clk_bit

    // Byte out, MSB first, then the target's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], g);
        end
        clk_bit(1'b1, g);
        ack = ~g;
    endtask : wbyte

    // Byte in, then the master's own acknowledge
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, g);
            d[i] = g;
        end
        clk_bit(~ack, g);
    endtask : rbyte
endmodule : i2crp_master_model

// >>> tb/testbench.sv
/*
 * Self-checking bench of the register port against a register model.
 * Assumes the master model paces the link at 80 ns per bit.
 */
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, nrst_n = 1'b0, scl, m_low, sda_line, sda_o, sda_oe;
    logic [5:0]  pins;
    logic        vsel = 1'b0, en = 1'b1, sfail = 1'b0, therm = 1'b0, hic = 1'b0, uvlo = 1'b0;
    logic [7:0]  act, cfg, d;
    logic [10:0] tmv;
    logic        busy, hs, a;
    int          mdl[8];
    int          failures = 0, n_checks = 0, cycles = 0;

    // Pull-up wins unless someone pulls low
    assign sda_line = ~(m_low | (sda_oe & ~sda_o));
    always #2.5 clk = ~clk;

    i2crp_master_model u_i2crp_master_model (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
    i2crp_top u_i2crp_top (.SYS_CLK_I(clk), .NRST_I(nrst_n), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .RESISTOR_SETTING_PIN_I(pins), .VOLTAGE_SELECT_INPUT_I(vsel),
        .ENABLE_I(en), .SUPPLY_FAIL_I(sfail), .THERMAL_WARN_I(therm), .HICCUP_I(hic), .UVLO_I(uvlo),
        .ACTIVE_VOLTAGE_CODE_O(act), .TARGET_MV_O(tmv), .CONFIGURATION_O(cfg),
        .STARTUP_BUSY_O(busy), .HS_MODE_O(hs));

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk_val(input string nm, input logic [10:0] e, input logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_flag(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %0b seen %0b", nm, e, g);
        end
    endtask : chk_flag

    // Register defaults as the model sees them
    task automatic mdl_rst();
        mdl = '{0, 8'h64, 8'h64, 8'h6f, 0, 0, 0, 0};
    endtask : mdl_rst

    // Single write; reset bit restores all defaults
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic a0, a1, a2;
        u_i2crp_master_model.start();
        u_i2crp_master_model.wbyte({1'b1, pins, 1'b0}, a0);
        u_i2crp_master_model.wbyte(p, a1);
        u_i2crp_master_model.wbyte(v, a2);
        u_i2crp_master_model.stop();
        chk_flag("write acks", 1'b1, a0 & a1 & a2);
        if (p == 8'h03 && v[7])
            mdl_rst();
        else if (p inside {8'h01, 8'h02, 8'h03})
            mdl[p[2:0]] = v;
    endtask : wr

    // Pointer write, repeated start, one byte back
    task automatic rd(input logic [7:0] p);
        logic a0, a1, a2;
        logic [7:0] g;
        u_i2crp_master_model.start();
        u_i2crp_master_model.wbyte({1'b1, pins, 1'b0}, a0);
        u_i2crp_master_model.wbyte(p, a1);
        u_i2crp_master_model.start();
        u_i2crp_master_model.wbyte({1'b1, pins, 1'b1}, a2);
        u_i2crp_master_model.rbyte(1'b0, g);
        u_i2crp_master_model.stop();
        chk_flag("read acks", 1'b1, a0 & a1 & a2);
        chk_val("read data", 11'(mdl[p[2:0]]), {3'h0, g});
        if (p == 8'h05)
            mdl[5] = 0;
    endtask : rd

    // Output code and millivolt target for a select level
    task automatic chk_sel(input logic s);
        @(negedge clk);
        vsel = s;
        repeat (6) @(negedge clk);
        chk_val("active code", 11'(mdl[s ? 2 : 1]), {3'h0, act});
        chk_val("target mv", 11'(400 + 5 * mdl[s ? 2 : 1]), tmv);
    endtask : chk_sel

    // Hang guard, well above the expected run of about 17000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        d = 8'($urandom(32'h541c7f9f));
        pins = 6'($urandom());
        mdl_rst();
        repeat (16) @(negedge clk);
        nrst_n = 1'b1;
        repeat (8) @(negedge clk);
        chk_val("configuration", 11'h06f, {3'h0, cfg});
        foreach (mdl[i]) rd(8'(i));
        for (int k = 1; k <= 2; k++) begin
            wr(8'(k), 8'($urandom()));
            rd(8'(k));
        end
        chk_sel(1'b0);
        chk_sel(1'b1);
        // Foreign address is left unanswered
        u_i2crp_master_model.start();
        u_i2crp_master_model.wbyte({1'b1, pins ^ 6'h01, 1'b0}, a);
        u_i2crp_master_model.stop();
        chk_flag("foreign ack", 1'b0, a);
        // Master code, then a transfer after a repeated start
        u_i2crp_master_model.start();
        u_i2crp_master_model.wbyte(8'h08 | 8'($urandom() & 7), a);
        chk_flag("code ack", 1'b0, a);
        chk_flag("high speed", 1'b1, hs);
        wr(8'h03, 8'h2e);
        repeat (6) @(negedge clk);
        chk_flag("high speed", 1'b0, hs);
        rd(8'h03);
        chk_val("configuration", 11'(mdl[3]), {3'h0, cfg});
        // Latched faults read once, then cleared
        {therm, hic, uvlo} = 3'h7;
        repeat (6) @(negedge clk);
        {therm, hic, uvlo} = 3'h0;
        mdl[5] = 8'h19;
        rd(8'h05);
        rd(8'h05);
        // Status register is read only; a write is taken but not stored
        wr(8'h05, 8'hff);
        rd(8'h05);
        // Reset bit restores defaults and raises start-up busy until it ends
        wr(8'h01, 8'h33);
        wr(8'h03, 8'h80);
        chk_flag("startup busy", 1'b1, busy);
        for (int w = 0; w < 400 && busy !== 1'b0; w++) @(negedge clk);
        chk_flag("startup busy", 1'b0, busy);
        rd(8'h01);
        rd(8'h03);
        chk_val("configuration", 11'(mdl[3]), {3'h0, cfg});
        // Enable fall and supply fail each restore defaults
        wr(8'h02, d);
        en = 1'b0;
        repeat (6) @(negedge clk);
        en = 1'b1;
        mdl_rst();
        repeat (300) @(negedge clk);
        rd(8'h02);
        chk_sel(1'b1);
        wr(8'h01, ~d);
        sfail = 1'b1;
        repeat (6) @(negedge clk);
        sfail = 1'b0;
        mdl_rst();
        repeat (300) @(negedge clk);
        rd(8'h01);
        chk_sel(1'b0);
        print_verdict();
    end
endmodule : testbench
